/* src/core_state.v */
/*
 * Programmer-visible state of an 8-bit processor core: accumulator,
 * index registers, stack pointer, program counter, flags word, data
 * memory with stack, read-only program store and vector fetches.
 * Assumes a single-cycle register port master and one system clock.
 */
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "core_state_map.vh"

// Summary of operation
// - Program store is read-only; data memory holds 192 read/write bytes with stack.
// - Writes aimed at program store are ignored and flagged.
// - Accumulator is 8 bits and pairs with Y as a 16-bit register.
// - Indexed address is the operand plus the chosen index register.
// - Stack pointer is 8 bits and selects the save or restore location.
// - Calls and accepted interrupts update the stack pointer automatically.
// - Program counter is 16 bits from high and low bytes, next instruction address.
// - After reset the counter loads from the vector at the two top addresses.
// - Counter increments wrap from the top address to zero.
// - Carry takes ALU carry or borrow and shift or rotate output.
// - Zero is set for a zero result, cleared otherwise.
// - Interrupt enable masks interrupts, clears on service, set and clear ops.
// - Half carry from bit 3 carry or no bit 4 borrow; cleared by overflow clear.
// - Software trap sets break to tell it from the table call.
// - Overflow set on signed overflow or by bit test, flags write or interrupt exit; cleared by overflow clear.
// - Negative follows bit 7 of each 8-bit result and bit 15 of the wide load result.
// - Bit test copies operand bits 6 and 7 into overflow and negative.
// - External 1 vector at FFF8, external 0 vector at FFFA.
// - Vector slots run from serial at E4 upward to reset at FE.
// - Table call fetches a two-byte entry per call number and jumps there.
// - Two-byte page call reaches the page call area; ordinary call is three bytes.
// - Stack pointer decrements after save, increments before restore; interrupt exit restores flags.
module core_state
(
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        rst,
    // Register port.
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Program store load port, usable only while in reset.
    input  wire        prog_load,
    input  wire [7:0]  prog_load_addr,
    input  wire [7:0]  prog_load_data,
    // Core state seen by the rest of the chip.
    output reg  [15:0] pc_out,
    output reg  [7:0]  flags_out,
    output reg         irq_enabled
);

    // Program store covers the top 256 addresses, which hold all vectors.
    reg [7:0]  prog_mem [0:(1<<`PROG_AW)-1];
    reg [7:0]  data_mem [0:`DATA_BYTES-1];

    reg [7:0]  acc;
    reg [7:0]  x_index;
    reg [7:0]  y_index;
    reg [7:0]  stack_pointer;
    reg [7:0]  counter_high_byte;
    reg [7:0]  counter_low_byte;
    reg [7:0]  processor_flags_word;
    reg [7:0]  operand;
    reg [7:0]  result;
    reg [15:0] eff_addr;
    reg [7:0]  mem_addr;
    reg        prog_write_refused;
    reg        vector_pending;
    reg        in_reset;

    reg [15:0] next_pc;
    reg [15:0] ret_addr;
    reg [8:0]  sum;
    reg [4:0]  low_sum;

    wire [15:0] program_counter = {counter_high_byte, counter_low_byte};
    wire [15:0] wide_pair_register = {y_index, acc};

    // Read a program byte; only the top page is implemented here.
    function [7:0] prog_byte;
        input [15:0] addr;
        begin
            prog_byte = prog_mem[addr[`PROG_AW-1:0]];
        end
    endfunction

    // Fetch a two-byte vector, low byte first.
    function [15:0] vector_at;
        input [15:0] addr;
        begin
            vector_at = {prog_byte(addr + `OP_LEN), prog_byte(addr)};
        end
    endfunction

    // Data memory address guard against the 192-byte limit.
    function in_data;
        input [7:0] addr;
        begin
            in_data = (addr < `DATA_BYTES);
        end
    endfunction

    // Program store load; no write path exists once out of reset.
    always @(posedge sys_clk)
    begin
        if (rst && prog_load)
            prog_mem[prog_load_addr] <= prog_load_data;
    end

    // ALU sum for add and subtract.
    always @*
    begin
        sum = 9'h000;
        low_sum = 5'h00;
        if (reg_wdata[4:0] == `OP_SUB)
        begin
            sum = {1'b0, acc} + {1'b0, ~operand} + 9'h001;
            low_sum = {1'b0, acc[3:0]} + {1'b0, ~operand[3:0]} + 5'h01;
        end
        else
        begin
            sum = {1'b0, acc} + {1'b0, operand};
            low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
        end
    end

    // Program counter step with wrap at the top address, and the full
    // 16-bit return address for each call length, so a low-byte carry reaches the high byte.
    always @*
    begin
        next_pc = program_counter + `OP_LEN;
        case (reg_wdata[4:0])
            `OP_CALL:  ret_addr = program_counter + `CALL_LEN;
            `OP_PAGED_SHORT_CALL: ret_addr = program_counter + `PAGED_SHORT_CALL_LEN;
            default:   ret_addr = program_counter + `OP_LEN;
        endcase
    end

    // Main state update.
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            acc                  <= 8'h00;
            x_index              <= 8'h00;
            y_index              <= 8'h00;
            processor_flags_word <= 8'h00;
            operand              <= 8'h00;
            result               <= 8'h00;
            eff_addr             <= 16'h0000;
            mem_addr             <= 8'h00;
            prog_write_refused   <= 1'b0;
            vector_pending       <= 1'b1;
            in_reset             <= 1'b1;
            counter_high_byte    <= 8'h00;
            counter_low_byte     <= 8'h00;
            // Stack pointer intentionally keeps its value over reset.
        end
        else if (vector_pending)
        begin
            {counter_high_byte, counter_low_byte} <= vector_at(`VEC_RESET);
            vector_pending <= 1'b0;
            in_reset       <= 1'b0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_ACC:      acc <= reg_wdata;
                `OFS_XIDX:     x_index <= reg_wdata;
                `OFS_YIDX:     y_index <= reg_wdata;
                `OFS_STACK:    stack_pointer <= reg_wdata;
                `OFS_PC_LOW:   counter_low_byte <= reg_wdata;
                `OFS_PC_HIGH:  counter_high_byte <= reg_wdata;
                `OFS_FLAGS:    processor_flags_word <= reg_wdata;
                `OFS_OPERAND:  operand <= reg_wdata;
                `OFS_MEM_ADDR: mem_addr <= reg_wdata;
                `OFS_MEM_DATA:
                begin
                    if (in_data(mem_addr))
                        data_mem[mem_addr] <= reg_wdata;
                end
                `OFS_PROG_STAT: prog_write_refused <= 1'b0;
                `OFS_OP:
                begin
                    case (reg_wdata[4:0])
                        `OP_ADD, `OP_SUB:
                        begin
                            acc <= sum[7:0];
                            result <= sum[7:0];
                            processor_flags_word[`FLAG_C] <= sum[8];
                            processor_flags_word[`FLAG_H] <= low_sum[4];
                            processor_flags_word[`FLAG_Z] <= (sum[7:0] == 8'h00);
                            processor_flags_word[`FLAG_N] <= sum[7];
                            if ((acc[7] == (operand[7] ^ (reg_wdata[4:0] == `OP_SUB)))
                                && (sum[7] != acc[7]))
                                processor_flags_word[`FLAG_V] <= 1'b1;
                        end
                        `OP_SHL:
                        begin
                            acc <= {acc[6:0], 1'b0};
                            result <= {acc[6:0], 1'b0};
                            processor_flags_word[`FLAG_C] <= acc[7];
                            processor_flags_word[`FLAG_Z] <= (acc[6:0] == 7'h00);
                            processor_flags_word[`FLAG_N] <= acc[6];
                        end
                        `OP_ROR:
                        begin
                            acc <= {processor_flags_word[`FLAG_C], acc[7:1]};
                            result <= {processor_flags_word[`FLAG_C], acc[7:1]};
                            processor_flags_word[`FLAG_C] <= acc[0];
                            processor_flags_word[`FLAG_Z] <=
                                ({processor_flags_word[`FLAG_C], acc[7:1]} == 8'h00);
                            processor_flags_word[`FLAG_N] <= processor_flags_word[`FLAG_C];
                        end
                        `OP_LOAD:
                        begin
                            acc <= operand;
                            result <= operand;
                            processor_flags_word[`FLAG_Z] <= (operand == 8'h00);
                            processor_flags_word[`FLAG_N] <= operand[7];
                        end
                        `OP_WIDE_LOAD:
                        begin
                            // Operand goes to Y, accumulator stays as the low half.
                            y_index <= operand;
                            processor_flags_word[`FLAG_Z] <= ({operand, acc} == 16'h0000);
                            processor_flags_word[`FLAG_N] <= operand[7];
                        end
                        `OP_ON:  processor_flags_word[`FLAG_I] <= 1'b1;
                        `OP_OFF: processor_flags_word[`FLAG_I] <= 1'b0;
                        `OP_OVERFLOW_CLEAR_OP:
                        begin
                            processor_flags_word[`FLAG_V] <= 1'b0;
                            processor_flags_word[`FLAG_H] <= 1'b0;
                        end
                        `OP_BITTEST:
                        begin
                            processor_flags_word[`FLAG_V] <= operand[6];
                            processor_flags_word[`FLAG_N] <= operand[7];
                            processor_flags_word[`FLAG_Z] <= ((acc & operand) == 8'h00);
                        end
                        `OP_INDEX_X:
                            eff_addr <= {8'h00, operand} + {8'h00, x_index};
                        `OP_INDEX_Y:
                            eff_addr <= {8'h00, operand} + {8'h00, y_index};
                        `OP_STEP:
                            {counter_high_byte, counter_low_byte} <= next_pc;
                        `OP_CALL, `OP_PAGED_SHORT_CALL, `OP_TABLE_VECTORED_CALL:
                        begin
                            // Return address is pushed high then low byte.
                            data_mem[stack_pointer] <= ret_addr[15:8];
                            data_mem[stack_pointer - 8'h01] <= ret_addr[7:0];
                            if (reg_wdata[4:0] == `OP_CALL)
                                {counter_high_byte, counter_low_byte} <= {operand, result};
                            stack_pointer <= stack_pointer - 8'h02;
                            if (reg_wdata[4:0] == `OP_PAGED_SHORT_CALL)
                                {counter_high_byte, counter_low_byte} <=
                                    {`PAGED_SHORT_CALL_PAGE, operand};
                            if (reg_wdata[4:0] == `OP_TABLE_VECTORED_CALL)
                                {counter_high_byte, counter_low_byte} <= vector_at(
                                    `VEC_TABLE_VECTORED_CALL_TOP - {11'h000, operand[3:0], 1'b0});
                        end
                        `OP_TRAP, `OP_IRQ:
                        begin
                            // A masked request is not accepted, so the stack stays as it is.
                            if ((reg_wdata[4:0] == `OP_TRAP)
                                || processor_flags_word[`FLAG_I])
                            begin
                                // Save counter and flags word, then vector out.
                                data_mem[stack_pointer] <= program_counter[15:8];
                                data_mem[stack_pointer - 8'h01] <= program_counter[7:0];
                                data_mem[stack_pointer - 8'h02] <= processor_flags_word
                                    | ((reg_wdata[4:0] == `OP_TRAP) ? 8'h10 : 8'h00);
                                stack_pointer <= stack_pointer - 8'h03;
                                processor_flags_word[`FLAG_I] <= 1'b0;
                                if (reg_wdata[4:0] == `OP_TRAP)
                                begin
                                    processor_flags_word[`FLAG_B] <= 1'b1;
                                    {counter_high_byte, counter_low_byte} <=
                                        vector_at(`VEC_TABLE_VECTORED_CALL_TOP);
                                end
                                else
                                    // Slot FFE0 + 2n: n=2 is serial at E4, n=13 external 0 at FA.
                                    {counter_high_byte, counter_low_byte} <= vector_at(
                                        `VEC_BASE + {11'h000, operand[3:0], 1'b0});
                            end
                        end
                        `OP_RET:
                        begin
                            counter_low_byte  <= data_mem[stack_pointer + 8'h01];
                            counter_high_byte <= data_mem[stack_pointer + 8'h02];
                            stack_pointer <= stack_pointer + 8'h02;
                        end
                        `OP_IRET:
                        begin
                            processor_flags_word <= data_mem[stack_pointer + 8'h01];
                            counter_low_byte  <= data_mem[stack_pointer + 8'h02];
                            counter_high_byte <= data_mem[stack_pointer + 8'h03];
                            stack_pointer <= stack_pointer + 8'h03;
                        end
                        `OP_PROG_WRITE: prog_write_refused <= 1'b1;
                        default: result <= result;
                    endcase
                end
                default: result <= result;
            endcase
        end
    end

    // Register read path, data one cycle after the strobe.
    always @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `OFS_ACC:       reg_rdata <= acc;
                `OFS_XIDX:      reg_rdata <= x_index;
                `OFS_YIDX:      reg_rdata <= wide_pair_register[15:8];
                `OFS_STACK:     reg_rdata <= stack_pointer;
                `OFS_PC_LOW:    reg_rdata <= counter_low_byte;
                `OFS_PC_HIGH:   reg_rdata <= counter_high_byte;
                `OFS_FLAGS:     reg_rdata <= processor_flags_word;
                `OFS_OPERAND:   reg_rdata <= operand;
                `OFS_RESULT:    reg_rdata <= result;
                `OFS_EA_LOW:    reg_rdata <= eff_addr[7:0];
                `OFS_EA_HIGH:   reg_rdata <= eff_addr[15:8];
                `OFS_MEM_ADDR:  reg_rdata <= mem_addr;
                `OFS_MEM_DATA:  reg_rdata <= in_data(mem_addr) ? data_mem[mem_addr] : 8'h00;
                `OFS_PROG_STAT: reg_rdata <= {7'h00, prog_write_refused};
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

    // Registered copies of core state for the rest of the chip.
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            pc_out      <= 16'h0000;
            flags_out   <= 8'h00;
            irq_enabled <= 1'b0;
        end
        else
        begin
            pc_out      <= program_counter;
            flags_out   <= processor_flags_word;
            irq_enabled <= processor_flags_word[`FLAG_I] & ~in_reset;
        end
    end

endmodule // core_state

/* src/core_state_map.vh */
/*
 * Constants for the processor core state block: register port offsets,
 * flag bit positions, vector addresses, memory sizes and operation codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CORE_STATE_MAP_VH
`define CORE_STATE_MAP_VH

// Register port offsets.
`define OFS_ACC         4'h0
`define OFS_XIDX        4'h1
`define OFS_YIDX        4'h2
`define OFS_STACK       4'h3
`define OFS_PC_LOW      4'h4
`define OFS_PC_HIGH     4'h5
`define OFS_FLAGS       4'h6
`define OFS_OP          4'h7
`define OFS_OPERAND     4'h8
`define OFS_RESULT      4'h9
`define OFS_EA_LOW      4'ha
`define OFS_EA_HIGH     4'hb
`define OFS_MEM_ADDR    4'hc
`define OFS_MEM_DATA    4'hd
`define OFS_PROG_STAT   4'he

// Flag bit positions in the flags word.
`define FLAG_C          3'd0
`define FLAG_Z          3'd1
`define FLAG_I          3'd2
`define FLAG_H          3'd3
`define FLAG_B          3'd4
`define FLAG_V          3'd6
`define FLAG_N          3'd7

// Operation codes written to the operation register.
`define OP_NONE         5'h00
`define OP_ADD          5'h01
`define OP_SUB          5'h02
`define OP_SHL          5'h03
`define OP_ROR          5'h04
`define OP_LOAD         5'h05
`define OP_ON           5'h06
`define OP_OFF          5'h07
`define OP_OVERFLOW_CLEAR_OP         5'h08
`define OP_BITTEST      5'h09
`define OP_CALL         5'h0a
`define OP_PAGED_SHORT_CALL        5'h0b
`define OP_TABLE_VECTORED_CALL        5'h0c
`define OP_TRAP         5'h0d
`define OP_IRQ          5'h0e
`define OP_RET          5'h0f
`define OP_IRET         5'h10
`define OP_INDEX_X      5'h11
`define OP_INDEX_Y      5'h12
`define OP_STEP         5'h13
`define OP_WIDE_LOAD    5'h14
`define OP_PROG_WRITE   5'h15

// Vector and call area addresses.
`define VEC_RESET       16'hfffe
`define VEC_BASE        16'hffe0
`define VEC_TABLE_VECTORED_CALL_TOP   16'hffde
`define PAGED_SHORT_CALL_PAGE      8'hff
`define CALL_LEN        16'h0003
`define PAGED_SHORT_CALL_LEN       16'h0002
`define OP_LEN          16'h0001

// Memory sizes.
`define DATA_BYTES      192
`define DATA_AW         8
`define PROG_AW         8

`endif

/* tb/core_state_chk.sv */
/* Checker for core_state: reset vector load, flag updates, interrupt
   enable and refused memory reads. Bound to every core_state instance. */
`timescale 1ns/1ps
module core_state_chk
(
    // Clock and reset.
    input wire        sys_clk,
    input wire        rst,
    // Register port.
    input wire [3:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // Program store load.
    input wire        prog_load,
    input wire [7:0]  prog_load_addr,
    input wire [7:0]  prog_load_data,
    // Core state.
    input wire [15:0] pc_out,
    input wire [7:0]  flags_out,
    input wire        irq_enabled
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] vec_lo, vec_hi, opnd, mem_sel;
    // Writes that may legally raise overflow: add, sub, bit test, exit, flags.
    wire op_wr = reg_wr && reg_addr == 4'h7;
    wire v_src = (op_wr && reg_wdata inside {8'h01, 8'h02, 8'h09, 8'h10})
                 || (reg_wr && reg_addr == 4'h6);
    // Shadows of the reset vector, the operand and the memory address.
    always_ff @(posedge sys_clk)
    begin
        if (rst && prog_load && prog_load_addr == 8'hfe)
            vec_lo <= prog_load_data;
        if (rst && prog_load && prog_load_addr == 8'hff)
            vec_hi <= prog_load_data;
        if (reg_wr && reg_addr == 4'h8)
            opnd <= reg_wdata;
        if (reg_wr && reg_addr == 4'hc)
            mem_sel <= reg_wdata;
    end
    reset_vector_a: assert property ($fell(rst) |-> ##[1:3] pc_out == {vec_hi, vec_lo})
        else $error("program counter missed the reset vector");
    irq_on_a: assert property (op_wr && reg_wdata == 8'h06 |-> ##[1:2] irq_enabled)
        else $error("enable op did not set the interrupt flag");
    irq_off_a: assert property (op_wr && reg_wdata == 8'h07 |-> ##[1:2] !irq_enabled)
        else $error("disable op did not clear the interrupt flag");
    irq_serve_a: assert property (op_wr && reg_wdata == 8'h0e |-> ##[1:3] !irq_enabled)
        else $error("interrupt flag still set after service");
    overflow_clear_op_clears_a: assert property (op_wr && reg_wdata == 8'h08 |-> ##2 flags_out[6] == 1'b0
        && flags_out[3] == 1'b0) else $error("overflow clear left V or H set");
    ovf_source_a: assert property ($rose(flags_out[6]) |-> $past(v_src, 1) || $past(v_src, 2))
        else $error("overflow set without a cause");
    bit_copy_a: assert property (op_wr && reg_wdata == 8'h09 |-> ##2 flags_out[7:6] == opnd[7:6])
        else $error("bit test did not copy operand bits");
    zero_flag_a: assert property (op_wr && reg_wdata == 8'h05 |-> ##2 flags_out[1] == (opnd == 8'h00))
        else $error("zero flag wrong after load");
    mem_refuse_a: assert property (reg_rd && reg_addr == 4'hd && mem_sel >= 8'd192 |=> reg_rdata == 8'h00)
        else $error("read beyond data memory not zero");
    cover property (op_wr && reg_wdata == 8'h0e && irq_enabled);
    cover property (op_wr && reg_wdata == 8'h09);
    cover property ($rose(flags_out[6]));
endmodule // core_state_chk
bind core_state core_state_chk core_state_chk_i
(
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_load(prog_load),
    .prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data),
    .pc_out(pc_out), .flags_out(flags_out), .irq_enabled(irq_enabled)
);

/* tb/testbench.sv */
/* Testbench for core_state: drives the register port and checks read
   data against expected values. Assumes the design sources under src/. */
`timescale 1ns/1ps
`define CHK(g, e) chk(16'(g), 16'(e))
module testbench;
    logic        sys_clk;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        prog_load;
    logic [7:0]  prog_load_addr;
    logic [7:0]  prog_load_data;
    logic [15:0] pc_out;
    logic [7:0]  flags_out;
    logic        irq_enabled;
    integer      n_errors;
    integer      cmp_count;
    logic [7:0]  pa [10];
    logic [7:0]  pd [10];
    core_state core_state_i
    (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_load(prog_load),
        .prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data),
        .pc_out(pc_out), .flags_out(flags_out), .irq_enabled(irq_enabled)
    );
    // Clock at 50 MHz.
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
            n_errors = n_errors + 1;
        end
    endtask
    // One write cycle on the register port.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    // One read cycle; the masked data of the next cycle is compared.
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata & m, e);
    endtask
    // Sets the operand, then issues an operation code.
    task automatic op(input logic [7:0] c, input logic [7:0] v);
        wr(4'h8, v);
        wr(4'h7, c);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short after about 5000 cycles.
    initial
    begin
        #100000;
        n_errors = n_errors + 1;
        give_verdict();
    end
    // Main sequence: program load in reset, then register level tests.
    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {prog_load, prog_load_addr, prog_load_data} = '0;
        pa = '{8'hfe, 8'hff, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hde, 8'hdf, 8'hdc, 8'hdd};
        pd = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h11, 8'h22, 8'hcd, 8'hab, 8'hef, 8'hbe};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge sys_clk);
            prog_load      <= 1'b1;
            prog_load_addr <= pa[i];
            prog_load_data <= pd[i];
        end
        @(posedge sys_clk);
        prog_load <= 1'b0;
        `CHK(pc_out, 16'h0000);
        repeat (9) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(4'h4, 8'hff, 8'h34);
        rd(4'h5, 8'hff, 8'h12);
        wr(4'h3, 8'hbf);
        rd(4'h3, 8'hff, 8'hbf);
        $display("test reset and stack pointer done");
        wr(4'h0, 8'h7f);
        op(8'h01, 8'h01);
        rd(4'h0, 8'hff, 8'h80);
        rd(4'h9, 8'hff, 8'h80);
        rd(4'h6, 8'hcb, 8'hc8);
        op(8'h08, 8'h00);
        rd(4'h6, 8'h48, 8'h00);
        wr(4'h0, 8'hff);
        op(8'h01, 8'h01);
        rd(4'h6, 8'hcb, 8'h0b);
        wr(4'h0, 8'h00);
        op(8'h02, 8'h01);
        rd(4'h6, 8'hcb, 8'h80);
        wr(4'h0, 8'h81);
        op(8'h03, 8'h00);
        rd(4'h6, 8'h01, 8'h01);
        op(8'h04, 8'h00);
        rd(4'h6, 8'h01, 8'h00);
        op(8'h05, 8'h00);
        rd(4'h6, 8'h82, 8'h02);
        op(8'h09, 8'h40);
        rd(4'h6, 8'hc0, 8'h40);
        op(8'h09, 8'h80);
        rd(4'h6, 8'hc0, 8'h80);
        $display("test flags done");
        wr(4'h1, 8'h10);
        op(8'h11, 8'h30);
        rd(4'ha, 8'hff, 8'h40);
        wr(4'h2, 8'hf0);
        op(8'h12, 8'hf0);
        rd(4'ha, 8'hff, 8'he0);
        rd(4'hb, 8'hff, 8'h01);
        op(8'h14, 8'h12);
        rd(4'h2, 8'hff, 8'h12);
        wr(4'hc, 8'hbf);
        wr(4'hd, 8'h5a);
        rd(4'hd, 8'hff, 8'h5a);
        wr(4'hc, 8'hc0);
        wr(4'hd, 8'ha5);
        rd(4'hd, 8'hff, 8'h00);
        op(8'h15, 8'h00);
        rd(4'he, 8'hff, 8'h01);
        wr(4'he, 8'h00);
        rd(4'he, 8'hff, 8'h00);
        $display("test index and memory done");
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h20);
        wr(4'h3, 8'hbf);
        op(8'h07, 8'h00);
        op(8'h0e, 8'h0d);
        rd(4'h5, 8'hff, 8'h20);
        op(8'h06, 8'h00);
        rd(4'h6, 8'h04, 8'h04);
        op(8'h0e, 8'h0d);
        rd(4'h5, 8'hff, 8'h22);
        rd(4'h3, 8'hff, 8'hbc);
        rd(4'h6, 8'h04, 8'h00);
        op(8'h10, 8'h00);
        rd(4'h5, 8'hff, 8'h20);
        rd(4'h3, 8'hff, 8'hbf);
        rd(4'h6, 8'h04, 8'h04);
        op(8'h0e, 8'h0c);
        rd(4'h4, 8'hff, 8'h78);
        $display("test interrupts done");
        wr(4'h3, 8'hbf);
        op(8'h0d, 8'h00);
        rd(4'h4, 8'hff, 8'hcd);
        rd(4'h5, 8'hff, 8'hab);
        wr(4'hc, 8'hbd);
        rd(4'hd, 8'h10, 8'h10);
        op(8'h0c, 8'h01);
        rd(4'h5, 8'hff, 8'hbe);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h20);
        wr(4'h3, 8'hbf);
        op(8'h0b, 8'h20);
        rd(4'h4, 8'hff, 8'h20);
        rd(4'h5, 8'hff, 8'hff);
        rd(4'h3, 8'hff, 8'hbd);
        op(8'h0f, 8'h00);
        rd(4'h4, 8'hff, 8'h02);
        op(8'h0a, 8'h30);
        rd(4'h5, 8'hff, 8'h30);
        rd(4'h3, 8'hff, 8'hbd);
        op(8'h0f, 8'h00);
        rd(4'h4, 8'hff, 8'h05);
        $display("test calls done");
        wr(4'h4, 8'hff);
        wr(4'h5, 8'hff);
        op(8'h13, 8'h00);
        @(posedge sys_clk);
        #1;
        `CHK(pc_out, 16'h0000);
        $display("test counter wrap done");
        give_verdict();
    end
endmodule // testbench
